// file: tb_uep0_core.sv
// Self-checking bench for the endpoint-zero core and a host model.
// Assumes a 50 MHz clock; the frame timer is cut to 64 cycles.
`timescale 1ns/1ns
`default_nettype none
module tb_uep0_core
   import uep0_pkg::*;
;
   localparam int TMO = 64;
   localparam int ST_BYTE = 0, ST_INREQ = 1, ST_SOF = 2;
   localparam int ST_DONE = 3, ST_BRST = 4, ST_TOK = 5;
   logic        clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, pready, pslverr, e, irq, cpu_reset;
   logic [7:0]  paddr = 8'h00, ram_rdata, out_data, in_data, up_d;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic        setup_valid, status_done, bus_reset, addr_match, sof_valid;
   logic        out_valid, in_req, in_data_valid, status_ack;
   logic        req_standard, req_vendor;
   logic [6:0]  tok_addr;
   logic [10:0] sof_frame;
   logic [7:0]  wr_d;
   logic [15:0] wr_a;
   uep0_setup_t setup;
   uep0_ram_t   ram;
   int          error_cnt = 0, compares = 0, wr_n = 0, ack_n = 0;
   // Clock; the RAM stand-in answers from its address alone, whether or not its read strobe stands.
   always #10 clk_sys = ~clk_sys;
   assign ram_rdata = ram.addr[7:0] ^ 8'h3c;
   always @(posedge clk_sys) begin
      if (ram.we === 1'b1) {wr_n, wr_a, wr_d} <= {wr_n + 1, ram.addr, ram.wdata};
      if (status_ack === 1'b1) ack_n <= ack_n + 1;
      if (in_data_valid === 1'b1) up_d <= in_data;
   end
   uep0_core #(.TIMEOUT_CYC(TMO)) dut (.clk_sys, .rst, .paddr, .psel,
      .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .setup_valid,
      .setup, .status_done, .bus_reset, .tok_addr, .addr_match, .sof_valid,
      .sof_frame, .out_valid, .out_data, .in_req, .in_data, .in_data_valid,
      .status_ack, .req_standard, .req_vendor, .ram, .ram_rdata, .cpu_reset,
      .irq);
   uep0_host_model host (.clk_sys, .setup, .setup_valid, .status_done,
      .bus_reset, .tok_addr, .sof_valid, .sof_frame, .out_valid, .out_data,
      .in_req);
   // Verdict and the end of the run.
   task automatic tally_and_finish;
      $display("mismatches %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // APB transfer; read data and error are taken at the ready edge.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 20);
      {q, e} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
      if (n == 20) begin
         error_cnt++;
         tally_and_finish;
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q, x);
   endtask
   task automatic ld(input logic [7:0] rt, input logic [15:0] v, len);
      host.send_setup(rt, UEP0_RQ_RAM_LOAD, v, 16'h0000, len);
   endtask
   // Address zero first; assignment, then re-enumeration or bus reset.
   task automatic t_addr;
      apb(1'b1, UEP0_OFS_FNADR, 32'h55);
      rd(UEP0_OFS_FNADR, 32'h0);
      rd(8'h40, 32'h0);
      chk(e, 1'b1);
      host.strobe(ST_TOK, 11'h000);
      chk(addr_match, 1'b1);
      for (int i = 0; i < 2; i++) begin
         host.send_setup(UEP0_RT_SET_ADR, UEP0_RQ_SET_ADR, 16'h0023, 0, 0);
         host.strobe(ST_DONE, 11'h0);
         rd(UEP0_OFS_FNADR, 32'h23);
         chk(addr_match, 1'b0);
         host.strobe(ST_TOK, 11'h023);
         chk(addr_match, 1'b1);
         if (i == 0) apb(1'b1, UEP0_OFS_CTRL, 32'h4);
         else host.strobe(ST_BRST, 11'h0);
         rd(UEP0_OFS_FNADR, 32'h0);
         chk(addr_match, 1'b0);
         host.strobe(ST_TOK, 11'h000);
      end
   endtask
   // Requests answered by firmware wait on the handshake bit.
   task automatic t_fw;
      int a;
      logic [7:0]  rt [2] = '{UEP0_RT_GET_IF, UEP0_RT_SYNC};
      logic [7:0]  rq [2] = '{UEP0_RQ_GET_IF, UEP0_RQ_SYNC};
      logic [15:0] ix [2] = '{16'h0003, 16'h0088};
      for (int i = 0; i < 2; i++) begin
         host.send_setup(rt[i], rq[i], 16'h0000, ix[i], 16'(i + 1));
         rd(UEP0_OFS_SETUPH, {16'(i + 1), ix[i]});
         apb(1'b1, UEP0_OFS_IRQ_MK, 32'h1);
         rd(UEP0_OFS_CTRL, 32'h1);
         chk(irq, 1'b1);
         chk(req_standard, 1'b1);
         a = ack_n;
         apb(1'b1, UEP0_OFS_CTRL, 32'h1);
         apb(1'b1, UEP0_OFS_IRQ_ST, 32'h1);
         rd(UEP0_OFS_CTRL, 32'h0);
         chk(irq, 1'b0);
         chk(ack_n, a + 1);
      end
   endtask
   // Downloads in both modes, the CPU hold window, then an upload.
   task automatic t_load;
      int n, a;
      logic [15:0] ca [3] = '{16'hff01, 16'hff00, 16'hff00};
      logic [7:0]  cv [3] = '{8'h01, 8'h01, 8'h00};
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, UEP0_OFS_CTRL, 32'(m) << UEP0_CTRL_MODE);
         {n, a} = {wr_n, ack_n};
         ld(UEP0_RT_VND_OUT, 16'h0010, 16'h0002);
         host.strobe(ST_BYTE, 11'h0a5);
         host.strobe(ST_BYTE, 11'h05a);
         repeat (2) @(posedge clk_sys);
         chk(wr_n, n + 2);
         chk({wr_a, wr_d}, 24'h00115a);
         chk(ack_n, a + 1);
         chk(req_vendor, 1'b1);
      end
      // A loader holds the CPU, then lets it go.
      for (int i = 0; i < 3; i++) begin
         n = wr_n;
         ld(UEP0_RT_VND_OUT, ca[i], 16'h0001);
         host.strobe(ST_BYTE, {3'h0, cv[i]});
         repeat (2) @(posedge clk_sys);
         chk(cpu_reset, i == 1);
         chk(wr_n, n);
      end
      a = ack_n;
      ld(UEP0_RT_VND_IN, 16'h0020, 16'h0002);
      host.strobe(ST_INREQ, 11'h0);
      host.strobe(ST_INREQ, 11'h0);
      repeat (3) @(posedge clk_sys);
      chk(up_d, 8'h21 ^ 8'h3c);
      chk(ack_n, a + 1);
   endtask
   // Frame capture, its interrupt, and the timer's stand-in SOF.
   task automatic t_sof;
      apb(1'b1, UEP0_OFS_IRQ_MK, 32'h2);
      host.strobe(ST_SOF, 11'h5a3);
      rd(UEP0_OFS_FRM_HI, 32'h5);
      apb(1'b1, UEP0_OFS_IRQ_ST, 32'h2);
      rd(UEP0_OFS_FRM_LO, 32'ha3);
      chk(irq, 1'b0);
      repeat (TMO) @(posedge clk_sys);
      chk(irq, 1'b1);
      rd(UEP0_OFS_FRM_LO, 32'ha4);
   endtask
   // Main sequence after two cycles of reset, plus a hang guard.
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      t_addr;
      t_fw;
      t_load;
      t_sof;
      tally_and_finish;
   end
   initial begin
      #2000000;
      error_cnt++;
      tally_and_finish;
   end
endmodule // tb_uep0_core
`default_nettype wire

// file: uep0_core.sv
// Endpoint-zero request handling, address assignment, RAM load and
// frame count capture, with an APB register slave and one interrupt.
// Assumes a serial engine that delivers setup packets, data bytes, SOF
// frame numbers and status-stage completion as one-cycle pulses.
// What this block does
// - Get_Interface setup flagged for firmware answering
// - Respond to address zero before assignment
// - Set_Address completion loads function address
// - Bus reset returns default address
// - Function address readable, CPU writes ignored
// - Re-enumeration clears function address
// - Sync_Frame setup flagged for firmware answering
// - Capture 11-bit SOF frame number
// - One shared SOF interrupt each frame
// - Frame timer raises SOF when missing
// - Decode request type bits 6:5
// - Vendor download writes RAM from data stage
// - Vendor upload returns RAM contents
// - Load requests work in any mode
// - Direction bit picks download or upload
// - CPU control bit holds CPU reset
// - Download writes only CPU control register
// - Writing one clears handshake bit, releases status
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module uep0_core
   import uep0_pkg::*;
#(
   parameter int          TIMEOUT_CYC  = UEP0_TIMEOUT_CYC,
   parameter logic [15:0] REG_BASE     = 16'hff00,
   parameter logic [15:0] CPU_CTL_ADDR = 16'hff00
) (
   input  wire logic         clk_sys,        // System clock.
   input  wire logic         rst,            // Async reset, high.
   input  wire logic [7:0]   paddr,          // APB address.
   input  wire logic         psel,           // APB select.
   input  wire logic         penable,        // APB enable.
   input  wire logic         pwrite,         // APB write.
   input  wire logic [31:0]  pwdata,         // APB write data.
   output logic [31:0]       prdata,         // APB read data.
   output logic              pready,         // APB ready.
   output logic              pslverr,        // APB error.
   input  wire logic         setup_valid,    // Setup packet pulse.
   input  wire uep0_pkg::uep0_setup_t setup, // Setup packet bytes.
   input  wire logic         status_done,    // Status stage finished.
   input  wire logic         bus_reset,      // USB bus reset.
   input  wire logic [6:0]   tok_addr,       // Token device address.
   output logic              addr_match,     // Token is for us.
   input  wire logic         sof_valid,      // SOF received pulse.
   input  wire logic [10:0]  sof_frame,      // SOF frame number.
   input  wire logic         out_valid,      // Data stage byte in.
   input  wire logic [7:0]   out_data,       // Data stage byte.
   input  wire logic         in_req,         // Host wants a byte.
   output logic [7:0]        in_data,        // Upload byte.
   output logic              in_data_valid,  // Upload byte pulse.
   output logic              status_ack,     // Let status stage go.
   output logic              req_standard,   // Last setup standard.
   output logic              req_vendor,     // Last setup vendor.
   output uep0_pkg::uep0_ram_t ram,          // RAM strobes.
   input  wire logic [7:0]   ram_rdata,      // RAM read data.
   output logic              cpu_reset,      // Holds CPU in reset.
   output logic              irq             // Level interrupt.
);
   import uep0_pkg::*;

   localparam logic [15:0] ONE16 = 16'h0001;
   localparam logic [16:0] TMAX = 17'(TIMEOUT_CYC - 1);

   // Decoded strobes shared by the register processes.
   function automatic logic is_hit(input logic [7:0] ofs);
      is_hit = psel && penable && pwrite && (paddr == ofs);
   endfunction

   logic [6:0]        fn_addr, pend_addr;
   logic              pend_set, nak_bit, mode_bit;
   logic [10:0]       frame;
   logic [16:0]       ftimer;
   logic [UEP0_IRQ_W-1:0] irq_st, irq_mk;
   logic [7:0]        cpu_ctl;
   uep0_setup_t       setup_q;
   uep0_state_t       state;
   logic [15:0]       xaddr, xleft;
   logic              rd_pend, rd_reg, rd_cpu, sof_evt, timeout;
   logic              std_req, vnd_load, set_adr, reenumerate_mode_bit_go, nak_clr;
   logic [31:0]       next_rdata;
   logic              mapped;

   assign pready = 1'b1;

   // Request classification from the type and request bytes.
   assign std_req  = setup[UEP0_TYPE_LSB+1:UEP0_TYPE_LSB]
                     == UEP0_TYPE_STD;
   assign vnd_load = (setup.req_type[UEP0_TYPE_LSB+1:UEP0_TYPE_LSB]
                     == UEP0_TYPE_VENDOR)
                     && (setup.request == UEP0_RQ_RAM_LOAD)
                     && ((setup.req_type == UEP0_RT_VND_OUT)
                     || (setup.req_type == UEP0_RT_VND_IN));
   assign set_adr  = std_req && (setup.req_type == UEP0_RT_SET_ADR)
                     && (setup.request == UEP0_RQ_SET_ADR);
   assign reenumerate_mode_bit_go = is_hit(UEP0_OFS_CTRL) && pwdata[UEP0_CTRL_REENUMERATE_MODE_BIT];
   assign nak_clr  = is_hit(UEP0_OFS_CTRL) && pwdata[UEP0_CTRL_NAK];

   // Token filter on the live address, zero until assigned.
   assign addr_match = (tok_addr == fn_addr);

   // Function address; the only APB path is the re-enumerate clear, so the CPU cannot set it.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fn_addr <= UEP0_ADDR_DEFAULT;
      end else if (bus_reset) begin
         fn_addr <= UEP0_ADDR_DEFAULT;
      end else if (reenumerate_mode_bit_go) begin
         fn_addr <= UEP0_ADDR_DEFAULT;
      end else if (status_done && pend_set) begin
         fn_addr <= pend_addr;
      end
   end

   // New address waits for the status stage; the old one answers until.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pend_set  <= 1'b0;
         pend_addr <= UEP0_ADDR_DEFAULT;
      end else if (bus_reset || reenumerate_mode_bit_go) begin
         pend_set  <= 1'b0;
      end else if (setup_valid) begin
         pend_set  <= set_adr;
         pend_addr <= setup.value[6:0];
      end else if (status_done) begin
         pend_set  <= 1'b0;
      end
   end

   // Setup bytes kept for firmware to answer standard requests from.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         setup_q      <= '0;
         req_standard <= 1'b0;
         req_vendor   <= 1'b0;
      end else if (setup_valid) begin
         setup_q      <= setup;
         req_standard <= std_req;
         req_vendor   <= setup.req_type[UEP0_TYPE_LSB+1:UEP0_TYPE_LSB]
                         == UEP0_TYPE_VENDOR;
      end
   end

   // Handshake bit stalls firmware requests; a new setup beats a clear.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         nak_bit <= 1'b0;
      end else if (bus_reset) begin
         nak_bit <= 1'b0;
      end else if (setup_valid && !vnd_load && !set_adr) begin
         nak_bit <= 1'b1;
      end else if (nak_clr) begin
         nak_bit <= 1'b0;
      end
   end

   // Mode bit is plain storage; the load engine never looks at it.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mode_bit <= 1'b0;
      end else if (is_hit(UEP0_OFS_CTRL)) begin
         mode_bit <= pwdata[UEP0_CTRL_MODE];
      end
   end

   // Status release by firmware clear, by a Set_Address setup or by load byte count.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         status_ack <= 1'b0;
      end else begin
         status_ack <= (nak_clr && nak_bit && !setup_valid)
                    || (setup_valid && set_adr)
                    || (setup_valid && vnd_load
                        && setup.length == '0)
                    || (state == UEP0_DNLOAD && out_valid
                        && xleft == ONE16)
                    || (rd_pend && xleft == '0
                        && state == UEP0_UPLOAD);
      end
   end

   // Load engine; it is armed in either mode setting.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= UEP0_IDLE;
         xaddr <= '0;
         xleft <= '0;
      end else if (bus_reset) begin
         state <= UEP0_IDLE;
      end else if (setup_valid) begin
         xaddr <= setup.value;
         xleft <= setup.length;
         if (vnd_load && setup.length != '0) begin
            if (setup.req_type[UEP0_DIR_BIT]) begin
               state <= UEP0_UPLOAD;
            end else begin
               state <= UEP0_DNLOAD;
            end
         end else begin
            state <= UEP0_IDLE;
         end
      end else begin
         case (state)
            UEP0_IDLE: begin
               state <= UEP0_IDLE;
            end
            UEP0_DNLOAD: begin
               if (out_valid) begin
                  xaddr <= xaddr + ONE16;
                  xleft <= xleft - ONE16;
                  if (xleft == ONE16) begin
                     state <= UEP0_IDLE;
                  end
               end
            end
            UEP0_UPLOAD: begin
               if (in_req && xleft != '0) begin
                  xaddr <= xaddr + ONE16;
                  xleft <= xleft - ONE16;
               end else if (rd_pend && xleft == '0) begin
                  state <= UEP0_IDLE;
               end
            end
            default: begin
               state <= UEP0_IDLE;
            end
         endcase
      end
   end

   // RAM strobes; addresses in the register window never reach RAM.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ram <= '0;
      end else begin
         ram.we    <= state == UEP0_DNLOAD && out_valid
                      && xaddr < REG_BASE;
         ram.re    <= state == UEP0_UPLOAD && in_req
                      && xleft != '0 && xaddr < REG_BASE;
         ram.addr  <= xaddr;
         ram.wdata <= out_data;
      end
   end

   // Upload read pipeline: one cycle for the RAM to answer.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rd_pend <= 1'b0;
         rd_reg  <= 1'b0;
         rd_cpu  <= 1'b0;
      end else begin
         rd_pend <= state == UEP0_UPLOAD && in_req && xleft != '0;
         rd_reg  <= xaddr >= REG_BASE;
         rd_cpu  <= xaddr == CPU_CTL_ADDR;
      end
   end

   // Upload byte; the register window reads back only CPU control.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         in_data       <= '0;
         in_data_valid <= 1'b0;
      end else begin
         in_data_valid <= rd_pend;
         if (rd_pend) begin
            in_data <= rd_reg ? (rd_cpu ? cpu_ctl : 8'h00) : ram_rdata;
         end
      end
   end

   // CPU control; only a download writes it, so the CPU cannot free itself.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cpu_ctl <= UEP0_CPU_CTRL_RST;
      end else if (state == UEP0_DNLOAD && out_valid
                   && xaddr == CPU_CTL_ADDR) begin
         cpu_ctl <= out_data;
      end
   end

   assign cpu_reset = cpu_ctl[UEP0_CPU_RST_BIT];

   // Timer restarts on each SOF; its grace margin stops a double event
   // when a real SOF is only slightly late.
   assign timeout = (ftimer == TMAX);
   assign sof_evt = sof_valid || timeout;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ftimer <= '0;
      end else if (sof_evt || bus_reset) begin
         ftimer <= '0;
      end else begin
         ftimer <= ftimer + 17'h00001;
      end
   end

   // Frame number capture; a synthetic frame advances mod 2048.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         frame <= '0;
      end else if (sof_valid) begin
         frame <= sof_frame;
      end else if (timeout) begin
         frame <= frame + 11'h001;
      end
   end

   // Sticky interrupt status, write one to clear, set wins.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_st <= '0;
      end else begin
         for (int i = 0; i < UEP0_IRQ_W; i++) begin
            if ((i == UEP0_IRQ_SOF && sof_evt)
                || (i == UEP0_IRQ_SETUP && setup_valid
                    && !vnd_load && !set_adr)) begin
               irq_st[i] <= 1'b1;
            end else if (is_hit(UEP0_OFS_IRQ_ST) && pwdata[i]) begin
               irq_st[i] <= 1'b0;
            end
         end
      end
   end

   // Interrupt mask.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_mk <= '0;
      end else if (is_hit(UEP0_OFS_IRQ_MK)) begin
         irq_mk <= pwdata[UEP0_IRQ_W-1:0];
      end
   end

   assign irq = |(irq_st & irq_mk);

   // Read mux, sampled in the setup phase so data stands in access.
   always_comb begin
      next_rdata = '0;
      mapped     = 1'b1;
      case (paddr)
         UEP0_OFS_CTRL: begin
            next_rdata[UEP0_CTRL_NAK]  = nak_bit;
            next_rdata[UEP0_CTRL_MODE] = mode_bit;
         end
         UEP0_OFS_FNADR:  next_rdata[6:0] = fn_addr;
         UEP0_OFS_FRM_LO: next_rdata[7:0] = frame[7:0];
         UEP0_OFS_FRM_HI: next_rdata[2:0] = frame[10:8];
         UEP0_OFS_IRQ_ST: next_rdata[UEP0_IRQ_W-1:0] = irq_st;
         UEP0_OFS_IRQ_MK: next_rdata[UEP0_IRQ_W-1:0] = irq_mk;
         UEP0_OFS_SETUPL: next_rdata = setup_q[31:0];
         UEP0_OFS_SETUPH: next_rdata = setup_q[63:32];
         UEP0_OFS_CPUCTL: next_rdata[7:0] = cpu_ctl;
         default:         mapped = 1'b0;
      endcase
   end

   // Registered read data and error answer for unmapped addresses.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
         pslverr <= !mapped;
      end else if (!psel) begin
         pslverr <= 1'b0;
      end
   end

endmodule // uep0_core
`default_nettype wire

// file: uep0_core_sva.sv
// Port checker for the endpoint-zero core, bound to every instance.
// Assumes one clock domain and the core's active-high async reset.
`timescale 1ns/1ns
`default_nettype none
module uep0_core_sva
   import uep0_pkg::*;
(
   input wire logic                  clk_sys,       // Clock.
   input wire logic                  rst,           // Reset.
   input wire logic                  psel,          // APB select.
   input wire logic                  pwrite,        // APB write.
   input wire logic                  setup_valid,   // Setup strobe.
   input wire uep0_pkg::uep0_setup_t setup,         // Setup bytes.
   input wire logic                  status_done,   // Status done.
   input wire logic                  bus_reset,     // Bus reset.
   input wire logic [6:0]            tok_addr,      // Token address.
   input wire logic                  addr_match,    // Token is ours.
   input wire logic                  out_valid,     // Data byte.
   input wire logic                  in_req,        // Upload request.
   input wire logic                  in_data_valid, // Upload byte.
   input wire logic                  status_ack,    // Status release.
   input wire logic                  req_standard,  // Standard request.
   input wire logic                  req_vendor,    // Vendor request.
   input wire uep0_pkg::uep0_ram_t   ram,           // RAM strobes.
   input wire logic                  cpu_reset      // CPU hold.
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // The address moves only on completion, reset or a CPU write.
   a_reset_addr_zero: assert property (
      $past(bus_reset) |-> addr_match == (tok_addr == UEP0_ADDR_DEFAULT))
      else $error("match not default after reset");
   a_addr_hold: assert property (
      $stable(tok_addr) && !$past(status_done) && !$past(bus_reset) &&
      !$past(psel) |-> $stable(addr_match))
      else $error("match moved without cause");
   // Decode and RAM strobes follow their cause by one cycle, the upload byte by two.
   a_type_decode: assert property (setup_valid |=>
      req_vendor == ($past(setup.req_type[6:5]) == UEP0_TYPE_VENDOR) &&
      req_standard == ($past(setup.req_type[6:5]) == UEP0_TYPE_STD))
      else $error("type decode wrong");
   a_write_cause: assert property (ram.we |-> $past(out_valid))
      else $error("stray RAM write");
   a_read_cause: assert property (ram.re |-> $past(in_req))
      else $error("stray RAM read");
   a_upload_lat: assert property (
      in_data_valid |-> $past(in_req, 2) && $past(ram.re))
      else $error("upload byte late");
   // A CPU hold or status release needs a cause just before it.
   a_cpu_cause: assert property (
      $changed(cpu_reset) |-> $past(out_valid))
      else $error("stray CPU hold change");
   a_ack_cause: assert property (status_ack |->
      $past(setup_valid) || $past(out_valid) || $past(in_req, 2) ||
      ($past(psel) && $past(pwrite)))
      else $error("stray status release");
endmodule // uep0_core_sva
bind uep0_core uep0_core_sva u_sva (.clk_sys, .rst, .psel, .pwrite,
   .setup_valid, .setup, .status_done, .bus_reset, .tok_addr, .addr_match,
   .out_valid, .in_req, .in_data_valid, .status_ack, .req_standard,
   .req_vendor, .ram, .cpu_reset);
`default_nettype wire

// file: uep0_host_model.sv
// Host-side model: setup packets, data strobes, frame markers, resets.
// Assumes the core's clock; drives just after rising edges.
`timescale 1ns/1ns
`default_nettype none
module uep0_host_model
   import uep0_pkg::*;
(
   input  wire logic                  clk_sys,     // Clock.
   output var  uep0_pkg::uep0_setup_t setup,       // Setup bytes.
   output var  logic                  setup_valid, // Setup strobe.
   output var  logic                  status_done, // Status stage done.
   output var  logic                  bus_reset,   // Bus reset.
   output var  logic [6:0]            tok_addr,    // Token address.
   output var  logic                  sof_valid,   // Frame marker.
   output var  logic [10:0]           sof_frame,   // Frame number.
   output var  logic                  out_valid,   // Data byte strobe.
   output var  logic [7:0]            out_data,    // Data byte.
   output var  logic                  in_req       // Upload request.
);
   // Everything starts idle.
   initial begin
      {setup_valid, status_done, bus_reset, sof_valid, out_valid, in_req,
       tok_addr, setup, sof_frame, out_data} = '0;
   end
   // Data is inverted after its strobe so stale bytes never pass.
   task automatic send_setup(input logic [7:0] rt, rq,
                             input logic [15:0] val, idx, len);
      @(posedge clk_sys);
      setup_valid <= 1'b1;
      setup       <= {len, idx, val, rq, rt};
      @(posedge clk_sys);
      setup_valid <= 1'b0;
      setup       <= ~{len, idx, val, rq, rt};
   endtask
   // One-cycle strobe of kind k: byte, request, frame, done, reset; kind token sets an address that stays.
   task automatic strobe(input int k, input logic [10:0] v);
      @(posedge clk_sys);
      {out_valid, in_req, sof_valid} <= {k == 0, k == 1, k == 2};
      {status_done, bus_reset} <= {k == 3, k == 4};
      {out_data, sof_frame} <= {v[7:0], v};
      if (k == 5) tok_addr <= v[6:0];
      @(posedge clk_sys);
      {out_valid, in_req, sof_valid, status_done, bus_reset} <= 5'h00;
      {out_data, sof_frame} <= ~{v[7:0], v};
   endtask
endmodule // uep0_host_model
`default_nettype wire

// file: uep0_pkg.sv
// Package for the endpoint-zero request and frame logic.
// Assumes a 50 MHz system clock and 32-bit APB register access.
package uep0_pkg;

   // Register byte offsets on the APB side.
   localparam logic [7:0] UEP0_OFS_CTRL   = 8'h00;
   localparam logic [7:0] UEP0_OFS_FNADR  = 8'h04;
   localparam logic [7:0] UEP0_OFS_FRM_LO = 8'h08;
   localparam logic [7:0] UEP0_OFS_FRM_HI = 8'h0c;
   localparam logic [7:0] UEP0_OFS_IRQ_ST = 8'h10;
   localparam logic [7:0] UEP0_OFS_IRQ_MK = 8'h14;
   localparam logic [7:0] UEP0_OFS_SETUPL = 8'h18;
   localparam logic [7:0] UEP0_OFS_SETUPH = 8'h1c;
   localparam logic [7:0] UEP0_OFS_CPUCTL = 8'h20;

   // Control register bit positions.
   localparam int UEP0_CTRL_NAK   = 0;
   localparam int UEP0_CTRL_MODE  = 1;
   localparam int UEP0_CTRL_REENUMERATE_MODE_BIT = 2;

   // Interrupt status and mask bit positions.
   localparam int UEP0_IRQ_SETUP = 0;
   localparam int UEP0_IRQ_SOF   = 1;
   localparam int UEP0_IRQ_W     = 2;

   // Setup request decoding.
   localparam logic [7:0] UEP0_RT_GET_IF   = 8'h81;
   localparam logic [7:0] UEP0_RQ_GET_IF   = 8'h0a;
   localparam logic [7:0] UEP0_RT_SYNC     = 8'h82;
   localparam logic [7:0] UEP0_RQ_SYNC     = 8'h0c;
   localparam logic [7:0] UEP0_RT_SET_ADR  = 8'h00;
   localparam logic [7:0] UEP0_RQ_SET_ADR  = 8'h05;
   localparam logic [7:0] UEP0_RQ_RAM_LOAD = 8'ha0;
   localparam logic [7:0] UEP0_RT_VND_OUT  = 8'h40;
   localparam logic [7:0] UEP0_RT_VND_IN   = 8'hc0;
   localparam logic [1:0] UEP0_TYPE_STD    = 2'b00;
   localparam logic [1:0] UEP0_TYPE_VENDOR = 2'b10;
   localparam int         UEP0_TYPE_LSB    = 5;
   localparam int         UEP0_DIR_BIT     = 7;

   // Reset values.
   localparam logic [6:0] UEP0_ADDR_DEFAULT = 7'h00;
   localparam logic [7:0] UEP0_CPU_RUN      = 8'h00;
   localparam int         UEP0_CPU_RST_BIT  = 0;
   localparam logic [7:0] UEP0_CPU_CTRL_RST = UEP0_CPU_RUN;

   // Frame timing: one frame plus a small grace before a SOF is missed.
   localparam int UEP0_CLK_NS      = 20;
   localparam int UEP0_FRAME_NS    = 1000000;
   localparam int UEP0_GRACE_NS    = 20000;
   localparam int UEP0_TIMEOUT_CYC =
      (UEP0_FRAME_NS + UEP0_GRACE_NS + UEP0_CLK_NS - 1) / UEP0_CLK_NS;
   localparam int UEP0_FRAME_W     = 11;

   // Setup packet, byte 0 in the low bits.
   typedef struct packed {
      logic [15:0] length;
      logic [15:0] index;
      logic [15:0] value;
      logic [7:0]  request;
      logic [7:0]  req_type;
   } uep0_setup_t;

   // Write and read strobes toward the internal RAM.
   typedef struct packed {
      logic        we;
      logic        re;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } uep0_ram_t;

   typedef enum logic [1:0] {
      UEP0_IDLE   = 2'b00,
      UEP0_DNLOAD = 2'b01,
      UEP0_UPLOAD = 2'b10
   } uep0_state_t;

endpackage
